// ===== hdl/sba_arbiter.sv
`timescale 1ns/10ps
`default_nettype none
module sba_arbiter
  import sba_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [1:0] arbiter_policy_control,     // static policy from chip config
  input wire sba_req_type req0,                      // master 0 request
  input wire sba_req_type req1,                      // master 1 request
  output logic gnt0,                                 // address tenure granted, same cycle
  output logic gnt1,
  output logic stall0,                               // request pending but not granted
  output logic stall1,
  output sba_dten_type dten0,                        // data tenure for master 0
  output sba_dten_type dten1                         // data tenure for master 1
);

  ////////////////////////////////////////////////////////////////////////////
  // decode

  // map an address to its endpoint; below shared memory is core-local
  function automatic sba_ep_type ep_of(input logic [ADDR_W-1:0] a);
    sba_ep_type e;
    e = EP_NONE;
    if (a >= PERI_BASE) begin
      e = EP_PERI;
    end else if (a >= EXT_BASE) begin
      e = EP_EXT;
    end else if (a >= SHM_BASE && a <= SHM_LAST) begin
      e = EP_SHM;
    end
    return e;
  endfunction

  sba_ep_type ep0, ep1;                               // target endpoints
  logic [BANK_W-1:0] bank0, bank1;                    // shared memory bank
  logic live0, live1;                                 // enabled and in scope

  // only an enabled access in an arbitrated scope takes part
  always_comb begin
    ep0 = ep_of(req0.addr);
    ep1 = ep_of(req1.addr);
    bank0 = req0.addr[BANK_LSB +: BANK_W];
    bank1 = req1.addr[BANK_LSB +: BANK_W];
    live0 = req0.en && (ep0 != EP_NONE);
    live1 = req1.en && (ep1 != EP_NONE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [3:0] rr_q, rr_d;                             // alternation flag per endpoint
  logic [1:0] ws_q, ws_d;                             // program-space wait served
  logic [1:0] lk_q, lk_d;                             // rmw reservation held
  sba_ep_type lk_ep_q [2];                            // endpoint under reservation
  sba_ep_type lk_ep_d [2];
  logic [1:0] ct_q, ct_d;                             // continuous transfer running
  logic [1:0] tl_q, tl_d;                             // one-cycle tail after it
  sba_ep_type ct_ep_q [2];
  sba_ep_type ct_ep_d [2];
  sba_dten_type dt0_d, dt1_d;

  logic g0, g1;                                       // combinational grants
  logic el0, el1;                                     // eligible this cycle
  logic need_ws0, need_ws1;                           // waiting on program-space slot
  logic blk0, blk1;                                   // held off by the other's lock or continuous run
  logic contend;                                      // same endpoint collision
  logic win1;                                         // master 1 wins the collision

  ////////////////////////////////////////////////////////////////////////////
  // arbitration, fully combinational so no cycle is added

  always_comb begin
    rr_d = rr_q;
    ws_d = ws_q;
    win1 = 1'b0;
    // core program fetch from shared memory waits one slot first
    need_ws0 = live0 && ep0 == EP_SHM && req0.pspace && !ws_q[0];
    need_ws1 = live1 && ep1 == EP_SHM && req1.pspace && !ws_q[1];
    // the other's reservation or continuous run keeps us off that endpoint
    blk0 = (lk_q[1] && lk_ep_q[1] == ep0) || ((ct_q[1] || tl_q[1]) && ct_ep_q[1] == ep0);
    blk1 = (lk_q[0] && lk_ep_q[0] == ep1) || ((ct_q[0] || tl_q[0]) && ct_ep_q[0] == ep1);
    el0 = live0 && !need_ws0 && !blk0;
    el1 = live1 && !need_ws1 && !blk1;
    // shared memory only collides inside one bank
    contend = el0 && el1 && ep0 == ep1 && (ep0 != EP_SHM || bank0 == bank1);
    if (contend) begin
      unique case (sba_pol_type'(arbiter_policy_control))
        POL_M0: begin
          win1 = 1'b0;
        end
        POL_M1: begin
          win1 = 1'b1;
        end
        POL_RR: begin
          // flag clear picks m0 and sets, flag set picks m1 and clears
          win1 = rr_q[ep0];
          rr_d[ep0] = !rr_q[ep0];
        end
        default: begin
          win1 = 1'b0;                                // reserved code acts as m0 first
        end
      endcase
      g0 = !win1;
      g1 = win1;
    end else begin
      g0 = el0;
      g1 = el1;
      // any lone access sends the next collision back to m0
      if (g0) begin
        rr_d[ep0] = 1'b0;
      end
      if (g1) begin
        rr_d[ep1] = 1'b0;
      end
    end
    // the slot is spent on a stall cycle, then consumed by the grant
    if (need_ws0) begin
      ws_d[0] = 1'b1;
    end else if (g0) begin
      ws_d[0] = 1'b0;
    end
    if (need_ws1) begin
      ws_d[1] = 1'b1;
    end else if (g1) begin
      ws_d[1] = 1'b0;
    end
  end

  // reservation and continuous-transfer tracking
  always_comb begin
    lk_d = lk_q;
    lk_ep_d = lk_ep_q;
    ct_ep_d = ct_ep_q;
    // a granted rmw access keeps the endpoint for the follow-up access
    if (g0) begin
      lk_d[0] = req0.read_modify_write;
      lk_ep_d[0] = ep0;
    end
    if (g1) begin
      lk_d[1] = req1.read_modify_write;
      lk_ep_d[1] = ep1;
    end
    // shared memory treats continuous dma as ordinary accesses
    ct_d[0] = g0 && req0.dma_cont && ep0 != EP_SHM;
    ct_d[1] = g1 && req1.dma_cont && ep1 != EP_SHM;
    if (ct_d[0]) begin
      ct_ep_d[0] = ep0;
    end
    if (ct_d[1]) begin
      ct_ep_d[1] = ep1;
    end
    // the run ends when no further continuous beat is granted
    tl_d[0] = ct_q[0] && !ct_d[0] && CONT_TAIL != 0;
    tl_d[1] = ct_q[1] && !ct_d[1] && CONT_TAIL != 0;
  end

  // data tenures issue one cycle after their address tenures
  always_comb begin
    dt0_d.valid = g0;
    dt0_d.ep = ep0;
    dt0_d.bank = bank0;
    dt1_d.valid = g1;
    dt1_d.ep = ep1;
    dt1_d.bank = bank1;
  end

  // register all state; everything clears on reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rr_q <= 4'h0;
      ws_q <= 2'h0;
      lk_q <= 2'h0;
      lk_ep_q[0] <= EP_NONE;
      lk_ep_q[1] <= EP_NONE;
      ct_q <= 2'h0;
      tl_q <= 2'h0;
      ct_ep_q[0] <= EP_NONE;
      ct_ep_q[1] <= EP_NONE;
      dten0 <= '0;
      dten1 <= '0;
    end else begin
      rr_q <= rr_d;
      ws_q <= ws_d;
      lk_q <= lk_d;
      lk_ep_q <= lk_ep_d;
      ct_q <= ct_d;
      tl_q <= tl_d;
      ct_ep_q <= ct_ep_d;
      dten0 <= dt0_d;
      dten1 <= dt1_d;
    end
  end

  // grants stay combinational: a register here would cost the access a cycle
  always_comb begin
    gnt0 = g0;
    gnt1 = g1;
    stall0 = live0 && !g0;
    stall1 = live1 && !g1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  one_grant_a: assert property (@(posedge clk) disable iff (!nrst)
    (gnt0 && gnt1) |-> (ep0 != ep1 || (ep0 == EP_SHM && bank0 != bank1)))
    else $error("two grants on one endpoint");

  parallel_ep_a: assert property (@(posedge clk) disable iff (!nrst)
    (el0 && el1 && ep0 != ep1) |-> (gnt0 && gnt1))
    else $error("different endpoints not granted together");

  fixed_m0_a: assert property (@(posedge clk) disable iff (!nrst)
    (contend && arbiter_policy_control == POL_M0) |-> (gnt0 && !gnt1))
    else $error("fixed m0 policy broken");

  fixed_m1_a: assert property (@(posedge clk) disable iff (!nrst)
    (contend && arbiter_policy_control == POL_M1) |-> (gnt1 && !gnt0))
    else $error("fixed m1 policy broken");

  rr_alternate_a: assert property (@(posedge clk) disable iff (!nrst)
    (contend && arbiter_policy_control == POL_RR && gnt0)
      ##1 (contend && arbiter_policy_control == POL_RR && ep0 == $past(ep0)) |-> gnt1)
    else $error("round robin did not alternate");

  rr_reset_a: assert property (@(posedge clk) disable iff (!nrst)
    (!contend && gnt0 && ep0 == EP_EXT) ##1 (contend && arbiter_policy_control == POL_RR && ep0 == EP_EXT)
      |-> gnt0)
    else $error("lone access did not reset alternation");

  stall_no_gnt_a: assert property (@(posedge clk) disable iff (!nrst)
    (!req0.en || ep0 == EP_NONE) |-> !gnt0)
    else $error("out of scope request granted");

  data_order_a: assert property (@(posedge clk) disable iff (!nrst)
    gnt1 |=> (dten1.valid && dten1.ep == $past(ep1)))
    else $error("data tenure out of order");

  rmw_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    (gnt0 && req0.read_modify_write && !contend) |=> !(gnt1 && ep1 == $past(ep0)))
    else $error("rmw reservation broken");

  cont_tail_a: assert property (@(posedge clk) disable iff (!nrst)
    (gnt0 && req0.dma_cont && ep0 != EP_SHM) ##1 !(gnt0 && req0.dma_cont)
      |=> !(gnt1 && ep1 == $past(ep0, 2)))
    else $error("continuous tail not honoured");

  pspace_wait_a: assert property (@(posedge clk) disable iff (!nrst)
    ($rose(req0.en) && ep0 == EP_SHM && req0.pspace && !ws_q[0]) |-> !gnt0)
    else $error("program space wait missing");

endmodule // sba_arbiter
`default_nettype wire

// ===== shared/sba_pkg.sv
// Notes on behaviour
// - different endpoints granted together without arbitration
// - policy setting picks m0, m1 or round-robin
// - fixed policy grants favoured master first
// - round-robin starts at m0 then alternates
// - lone access resets alternation to m0
// - one flag per endpoint drives the round-robin table
// - grant decided in the request cycle
// - only enabled in-scope requests are arbitrated
// - data tenures follow address grant order
// - read-modify-write reserves next access for owner
// - continuous transfer blocks other until one after
// - shared memory ignores continuous, keeps rmw
// - same-bank accesses serialise, other banks parallel
// - eight banks of 8K words, zero waits
// - core program-space shared access adds one wait
package sba_pkg;

  // address and scope layout
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned BANK_LSB = 13;              // 8K words per bank
  localparam int unsigned BANK_W = 3;                 // eight banks
  localparam logic [ADDR_W-1:0] SHM_BASE = 24'h030000;
  localparam logic [ADDR_W-1:0] SHM_LAST = 24'h03FFFF;
  localparam logic [ADDR_W-1:0] EXT_BASE = 24'h040000;
  localparam logic [ADDR_W-1:0] PERI_BASE = 24'hFFF000;

  // timing counts, in clock cycles
  localparam int unsigned PSPACE_WAIT = 1;            // extra wait on shared program fetch
  localparam int unsigned CONT_TAIL = 1;              // gap after a continuous transfer

  // endpoints
  typedef enum logic [1:0] {
    EP_NONE = 2'h0,
    EP_EXT = 2'h1,
    EP_SHM = 2'h2,
    EP_PERI = 2'h3
  } sba_ep_type;

  // arbitration policy setting
  typedef enum logic [1:0] {
    POL_M0 = 2'h0,
    POL_M1 = 2'h1,
    POL_RR = 2'h2,
    POL_RSV = 2'h3
  } sba_pol_type;

  // one master request as presented after its own core/dma arbitration
  typedef struct packed {
    logic en;                                         // access enabled
    logic [ADDR_W-1:0] addr;                          // word address
    logic read_modify_write;                                        // part of a read_modify_write
    logic dma_cont;                                   // dma continuous transfer
    logic pspace;                                     // core program-space access
  } sba_req_type;

  // data tenure marker, one cycle behind the address grant
  typedef struct packed {
    logic valid;
    sba_ep_type ep;
    logic [BANK_W-1:0] bank;
  } sba_dten_type;

endpackage

// ===== tb/sba_master_model.sv
`timescale 1ns/10ps
`default_nettype none
// one shared bus master, its core and dma already merged
module sba_master_model
  import sba_pkg::*;
(
  input wire logic clk,
  input wire logic gnt,       // same-cycle grant
  output var sba_req_type req // held until granted
);
  initial req = '0;

  //////////////////////////////////////////////////////////////
  // hold r until n grants; last = cycle of last grant, -1 if refused
  // gnt is read mid-cycle, so flag updates at the edge cannot race it
  task automatic issue(input sba_req_type r, input int n, output int last);
    int g;
    logic hit;
    g = 0;
    last = -1;
    if (n > 0) begin
      req = r;
      for (int k = 0; k < 16 && g < n; k++) begin
        #3 hit = gnt;
        @(posedge clk);
        #1;
        if (hit === 1'b1) begin
          g++;
          last = k;
          // step to the next word only while beats are still owed
          if (g < n) req.addr = req.addr + 24'h000001;
        end
      end
      if (g < n) last = -1;
      req.en = 1'b0;
      req.addr = ~req.addr; // released lines never keep the old address
      // one idle edge, so a following call never re-raises en in the same step
      @(posedge clk);
      #1;
    end
  endtask
endmodule // sba_master_model
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import sba_pkg::*;
  logic clk;
  logic nrst;
  logic [1:0] pol;
  sba_req_type req0;
  sba_req_type req1;
  logic gnt0, gnt1, stall0, stall1;
  sba_dten_type dten0;
  sba_dten_type dten1;
  sba_dten_type q0[$]; // expected data tenures
  sba_dten_type q1[$];
  int errors;
  int samples_checked;
  int seed;
  int la;
  int lb;
  logic [31:0] r32;
  logic [2:0] b0;
  logic [2:0] b1;
  localparam logic [23:0] XA = 24'h041230; // external word
  localparam logic [23:0] SA = 24'h030100; // shared memory, bank 0

  sba_arbiter sba_arbiter_inst (.clk(clk), .nrst(nrst), .arbiter_policy_control(pol), .req0(req0),
    .req1(req1), .gnt0(gnt0), .gnt1(gnt1), .stall0(stall0), .stall1(stall1), .dten0(dten0), .dten1(dten1));
  sba_master_model master0_model (.clk(clk), .gnt(gnt0), .req(req0));
  sba_master_model master1_model (.clk(clk), .gnt(gnt1), .req(req1));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  //////////////////////////////////////////////////////////////
  // request with flags {rmw, cont, pspace}
  function automatic sba_req_type rq(input logic [23:0] a, input logic [2:0] f);
    rq = {1'b1, a, f};
  endfunction

  // note the tenure each grant should produce
  task automatic note(input sba_req_type r, input int n, ref sba_dten_type q[$]);
    sba_dten_type e;
    logic [23:0] a;
    for (int i = 0; i < n; i++) begin
      a = r.addr + 24'(i);
      e.valid = 1'b1;
      e.bank = a[15:13];
      e.ep = (a >= 24'hFFF000) ? EP_PERI : (a >= 24'h040000) ? EP_EXT : EP_SHM;
      if (a >= 24'h030000) q.push_back(e); // out of scope is never granted
    end
  endtask

  // both masters at once; master 0 may start da cycles late
  task automatic run(input sba_req_type a, input int na, input int da, input sba_req_type b, input int nb);
    note(a, na, q0);
    note(b, nb, q1);
    fork
      begin
        repeat (da) @(posedge clk);
        if (da > 0) #1;
        master0_model.issue(a, na, la);
      end
      master1_model.issue(b, nb, lb);
    join
  endtask

  task automatic chk(input string what, input int exp, input int got);
    samples_checked++;
    if (exp != got) begin
      errors++;
      $display("BAD %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic take(input string what, input sba_dten_type got, ref sba_dten_type q[$]);
    sba_dten_type e;
    e = '0;
    if (q.size() > 0) e = q.pop_front();
    samples_checked++;
    if (got !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, e, got);
    end
  endtask

  // a stall is an enabled in-scope request that got no grant this cycle
  task automatic stall_chk(input string what, input sba_req_type r, input logic g, input logic s);
    logic e;
    e = r.en && (r.addr >= SHM_BASE) && (g !== 1'b1);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("BAD %s expected %b seen %b", what, e, s);
    end
  endtask

  //////////////////////////////////////////////////////////////
  // watcher: every tenure must match the oldest note
  always @(posedge clk) begin
    #2;
    if (dten0.valid === 1'b1) take("dten0", dten0, q0);
    if (dten1.valid === 1'b1) take("dten1", dten1, q1);
    stall_chk("stall0", req0, gnt0, stall0);
    stall_chk("stall1", req1, gnt1, stall1);
  end

  task automatic results;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // hang guard
  initial begin
    #100000;
    errors++;
    results;
  end

  //////////////////////////////////////////////////////////////
  initial begin
    errors = 0;
    samples_checked = 0;
    seed = 32'h3fd371ce;
    nrst = 1'b0;
    pol = 2'h0;
    repeat (12) @(posedge clk);
    #1 nrst = 1'b1;
    @(posedge clk);
    #1;
    run(rq(XA, 3'h0), 1, 0, rq(SA, 3'h0), 1);
    chk("split m0", 0, la);
    chk("split m1", 0, lb);
    // every policy code; a lone access first restarts alternation
    for (int p = 0; p < 4; p++) begin
      pol = p[1:0];
      run('0, 0, 0, rq(XA, 3'h0), 1);
      run(rq(XA, 3'h0), 1, 0, rq(XA, 3'h0), 1);
      chk("contention m0", (p == 1) ? 1 : 0, la);
      chk("contention m1", (p == 1) ? 0 : 1, lb);
    end
    pol = 2'h2;
    run(rq(XA, 3'h0), 2, 0, rq(XA, 3'h0), 2);
    chk("alternation m0", 2, la);
    chk("alternation m1", 3, lb);
    pol = 2'h0;
    run(rq(24'h012345, 3'h0), 1, 0, rq(XA, 3'h0), 1);
    chk("out of scope m0", -1, la);
    chk("in scope m1", 0, lb);
    // random banks, the first pair forced onto one bank
    for (int i = 0; i < 6; i++) begin
      r32 = $random(seed);
      b0 = r32[2:0];
      b1 = (i == 0) ? r32[2:0] : r32[5:3];
      run(rq(SA | {8'h00, b0, 13'h0000}, 3'h0), 1, 0, rq(SA | {8'h00, b1, 13'h0000}, 3'h0), 1);
      chk("bank m0", 0, la);
      chk("bank m1", (b0 == b1) ? 1 : 0, lb);
    end
    run(rq(SA, 3'h1), 1, 0, '0, 0);
    chk("program fetch", 1, la);
    run(rq(XA, 3'h2), 3, 0, rq(XA, 3'h0), 1);
    // blocked in the cycle after the last beat and in the tail cycle after that
    chk("continuous tail", 5, lb);
    run(rq(SA, 3'h2), 3, 0, rq(SA, 3'h0), 1);
    chk("continuous shared", 3, lb);
    // favoured master still waits out the other's reservation
    pol = 2'h1;
    run(rq(XA, 3'h4), 1, 0, '0, 0);
    run(rq(XA, 3'h0), 1, 3, rq(XA, 3'h0), 1);
    chk("reserved owner", 0, la);
    chk("reserved other", 4, lb);
    repeat (2) @(posedge clk);
    chk("tenures left", 0, q0.size() + q1.size());
    results;
  end
endmodule // testbench
`default_nettype wire
